// File: pkg/sarop_pkg.sv
// sarop_pkg: constants and carrier types for the converter output port.
// assumes a 20 mhz system clock and an ahb-lite register bus.
package sarop_pkg;

    // system clock period in ns
    localparam int unsigned CLK_NS          = 50;

    // timing figures, ns
    localparam int unsigned BUSY_DROP_NS    = 85;
    localparam int unsigned CONV_TYP_NS     = 2300;
    localparam int unsigned CONV_MAX_NS     = 2500;
    localparam int unsigned SCLK_MIN_NS     = 92;
    localparam int unsigned SCLK_MAX_NS     = 98;

    // longest times round down
    localparam int unsigned BUSY_DROP_CYC   = (BUSY_DROP_NS / CLK_NS) < 1 ? 1 :
                                              BUSY_DROP_NS / CLK_NS;
    localparam int unsigned CONV_CYC        = CONV_TYP_NS / CLK_NS;
    localparam int unsigned CONV_MAX_CYC    = CONV_MAX_NS / CLK_NS;
    // internal bit clock half period: one system cycle is the closest the
    // 50 ns clock allows, so the generated period is 100 ns
    localparam int unsigned SCLK_HALF_CYC   = (SCLK_MIN_NS / 2) / CLK_NS < 1 ? 1 :
                                              (SCLK_MIN_NS / 2) / CLK_NS;

    localparam int unsigned RES_W           = 16;
    localparam int unsigned BYTE_W          = 8;
    localparam int unsigned SER_BITS        = 16;

    // register byte addresses
    localparam logic [7:0]  CTRL_ADDR       = 8'h00;
    localparam logic [7:0]  STAT_ADDR       = 8'h04;
    localparam logic [7:0]  SAMP_ADDR       = 8'h08;
    localparam logic [7:0]  RES_ADDR        = 8'h0c;

    // control register fields
    localparam int unsigned CTRL_FMT_BIT    = 0;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [15:0] FMT_FLIP        = 16'h8000;

    // idle pin levels in struct order: deselected, external clock, clock low
    localparam logic [5:0]  PIN_IDLE        = 6'h34;

    // pin group seen from the host side
    typedef struct packed {
        logic chip_select_n;
        logic read_convert_select;
        logic byte_half_select;
        logic clock_source_select;
        logic serial_clock_in;
        logic tag_in;
    } sarop_pins_t;

    typedef enum logic [1:0] {
        SAROP_IDLE = 2'b00,
        SAROP_CONV = 2'b01,
        SAROP_LOAD = 2'b10
    } sarop_state_t;

endpackage

// File: rtl/sarop_port.sv
// sarop_port: conversion start, parallel byte port and serial port
// assumes hclk 20 mhz; pins arrive asynchronous; sample word from an ahb write
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - drive bus only when rc high, cs low
// - byte select low upper, high lower byte
// - byte select may change freely any time
// - output register undefined until first conversion; here it reads zero until the first load
// - update output register, then raise busy
// - busy drops within 85 ns, low 2.5 us max; here busy drops up to five hclk cycles (250 ns) after the pins change
// - serial out always driven, never high impedance
// - internal mode: start sends 16 bits msb first
// - internal clock low after 16, then tag level
// - internal bit clock period 92 to 98 ns; the port gives 100 ns
// - external clock: msb first falling, lsb sixteenth
// - tag bits shift through after the result
// - ignore convert requests while busy low
// - format high straight binary, low twos complement
// - parallel read keeps register, serial shifts it
module sarop_port #(
    parameter int unsigned CONV_CYCLES = sarop_pkg::CONV_CYC
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire sarop_pkg::sarop_pins_t pins,
    output logic      [7:0]          parallel_data_out,
    output logic                     parallel_data_oe,
    output logic                     serial_data_out,
    output logic                     serial_bit_clock_out,
    output logic                     serial_bit_clock_oe,
    output logic                     busy_n
);

    // three-stage synchronisers for all pins
    localparam int unsigned NPIN = 6;
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] pv;
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            // a change counts only once stages two and three agree
            // reset to idle pin levels: a zero reset would fake a start
            // as soon as reset lifts
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1[gi] <= sarop_pkg::PIN_IDLE[gi];
                    s2[gi] <= sarop_pkg::PIN_IDLE[gi];
                    s3[gi] <= sarop_pkg::PIN_IDLE[gi];
                    pv[gi] <= sarop_pkg::PIN_IDLE[gi];
                end else begin
                    s1[gi] <= pins[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (s2[gi] == s3[gi]) begin
                        pv[gi] <= s3[gi];
                    end
                end
            end
        end
    endgenerate

    // field order of the packed struct, msb first
    logic cs_n;
    logic rc;
    logic byte_sel;
    logic ext_sel;
    logic xclk;
    logic tag;
    assign cs_n     = pv[5];
    assign rc       = pv[4];
    assign byte_sel = pv[3];
    assign ext_sel  = pv[2];
    assign xclk     = pv[1];
    assign tag      = pv[0];

    // ahb-lite slave: zero wait states, always okay
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        fmt_sb;
    logic [15:0] sample_word;
    logic [15:0] result;
    logic [15:0] shreg;
    logic        conv_run;
    logic        wr_go;
    logic        rd_go;
    assign wr_go = hsel && hready && htrans == sarop_pkg::HTRANS_NONSEQ && hwrite;
    assign rd_go = hsel && hready && htrans == sarop_pkg::HTRANS_NONSEQ && !hwrite;

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= wr_go;
            wr_addr <= haddr[7:0];
        end
    end

    // write data phase: format control and analog sample stand-in
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fmt_sb      <= sarop_pkg::CTRL_RESET[sarop_pkg::CTRL_FMT_BIT];
            sample_word <= 16'h0000;
        end else if (wr_pend) begin
            if (wr_addr == sarop_pkg::CTRL_ADDR) begin
                fmt_sb <= hwdata[sarop_pkg::CTRL_FMT_BIT];
            end
            if (wr_addr == sarop_pkg::SAMP_ADDR) begin
                sample_word <= hwdata[15:0];
            end
        end
    end

    // read data registered in the address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_go) begin
            unique case (haddr[7:0])
                sarop_pkg::CTRL_ADDR: hrdata <= {31'h0, fmt_sb};
                sarop_pkg::STAT_ADDR: hrdata <= {30'h0, conv_run, busy_n};
                sarop_pkg::SAMP_ADDR: hrdata <= {16'h0, sample_word};
                sarop_pkg::RES_ADDR:  hrdata <= {16'h0, result};
                default:              hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // conversion sequencer
    sarop_pkg::sarop_state_t state;
    logic [15:0] ccnt;
    logic        start_lvl;
    logic        start_d;
    logic        start_evt;
    logic        load_evt;
    logic        tag_cap;
    assign start_lvl = !cs_n && !rc;
    assign start_evt = start_lvl && !start_d && state == sarop_pkg::SAROP_IDLE;
    assign conv_run  = state != sarop_pkg::SAROP_IDLE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_d <= 1'b0;
        end else begin
            start_d <= start_lvl;
        end
    end

    // busy falls on the cycle after the start is seen, rises a cycle after load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state  <= sarop_pkg::SAROP_IDLE;
            ccnt   <= 16'h0000;
            busy_n <= 1'b1;
        end else begin
            unique case (state)
                sarop_pkg::SAROP_IDLE: begin
                    if (start_evt) begin
                        state  <= sarop_pkg::SAROP_CONV;
                        busy_n <= 1'b0;
                        ccnt   <= 16'h0000;
                    end
                end
                sarop_pkg::SAROP_CONV: begin
                    ccnt <= ccnt + 16'h0001;
                    if (ccnt == 16'(CONV_CYCLES - 2)) begin
                        state <= sarop_pkg::SAROP_LOAD;
                    end
                end
                sarop_pkg::SAROP_LOAD: begin
                    state  <= sarop_pkg::SAROP_IDLE;
                    busy_n <= 1'b1;
                end
                default: begin
                    state <= sarop_pkg::SAROP_IDLE;
                end
            endcase
        end
    end
    // load on the last conversion cycle so the byte port changes on the same edge that busy rises
    assign load_evt = state == sarop_pkg::SAROP_CONV && ccnt == 16'(CONV_CYCLES - 2);

    // output register load, formatted; zero until first load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result <= 16'h0000;
        end else if (load_evt) begin
            result <= fmt_sb ? sample_word : sample_word ^ sarop_pkg::FMT_FLIP;
        end
    end

    // serial shift register; internal or external bit clock
    logic       xclk_d;
    logic       xrise;
    logic       int_run;
    logic [4:0] int_bits;
    logic       int_phase;
    logic       ext_en;
    assign ext_en = ext_sel && !cs_n && rc;
    assign xrise  = ext_en && xclk && !xclk_d;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xclk_d <= 1'b0;
        end else begin
            xclk_d <= xclk;
        end
    end

    // internal clock: high one cycle, low one cycle, sixteen pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_run   <= 1'b0;
            int_bits  <= 5'h00;
            int_phase <= 1'b0;
        end else if (start_evt && !ext_sel) begin
            int_run   <= 1'b1;
            int_bits  <= 5'h00;
            int_phase <= 1'b0;
        end else if (int_run) begin
            int_phase <= !int_phase;
            if (int_phase) begin
                int_bits <= int_bits + 5'h01;
                if (int_bits == 5'(sarop_pkg::SER_BITS - 1)) begin
                    int_run <= 1'b0;
                end
            end
        end
    end

    // parallel reads never touch shreg; each clock pulse shifts it once, except that a load in the same cycle wins and the pulse is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shreg   <= 16'h0000;
            tag_cap <= 1'b0;
        end else if (load_evt) begin
            shreg <= fmt_sb ? sample_word : sample_word ^ sarop_pkg::FMT_FLIP;
        end else if (start_evt && !ext_sel) begin
            tag_cap <= tag;
        end else if (int_run && int_phase) begin
            shreg <= {shreg[14:0], tag_cap};
        end else if (xrise) begin
            shreg <= {shreg[14:0], tag};
        end
    end

    // serial pins: data changes on the rising edge in external mode, so the
    // msb put out at the first rise stands over the first falling edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_data_out      <= 1'b0;
            serial_bit_clock_out <= 1'b0;
            serial_bit_clock_oe  <= 1'b0;
        end else begin
            serial_bit_clock_oe  <= !ext_sel;
            serial_bit_clock_out <= int_run && int_phase;
            if (!ext_sel || xrise || load_evt) begin
                serial_data_out <= shreg[15];
            end
        end
    end

    // parallel byte port, byte select sampled every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            parallel_data_out <= 8'h00;
            parallel_data_oe  <= 1'b0;
        end else begin
            parallel_data_oe  <= rc && !cs_n;
            parallel_data_out <= byte_sel ? result[7:0] : result[15:8];
        end
    end

    // busy low stays bounded; the sample that sees the fall is the first
    localparam int BUSY_LOW_MAX = int'(sarop_pkg::CONV_MAX_CYC) - 1;
    conv_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(busy_n) |-> busy_n == 1'b0 [*1] ##[1:BUSY_LOW_MAX] busy_n)
        else $error("busy low too long");
    start_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start_evt |=> !busy_n)
        else $error("busy did not drop");
    sequence load_s;
        load_evt ##2 busy_n;
    endsequence
    load_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(busy_n) |-> $past(load_evt, 2))
        else $error("busy rose before load");
    ignore_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !busy_n |-> !start_evt)
        else $error("start taken while busy");
    bus_en_a: assert property (@(posedge hclk) disable iff (!hresetn)
        parallel_data_oe |-> $past(rc && !cs_n))
        else $error("bus driven wrongly");
    byte_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(byte_sel) |-> parallel_data_out == $past(result[7:0]))
        else $error("wrong byte");
    int_clk_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(serial_bit_clock_out) |=> !serial_bit_clock_out)
        else $error("bit clock high too long");
    int_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(int_run) |=> !serial_bit_clock_out [*2])
        else $error("bit clock after sixteen");
    fmt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        load_s |-> result[15] == ($past(sample_word[15], 2) ^ !$past(fmt_sb, 2)))
        else $error("format wrong");
    ext_shift_a: assert property (@(posedge hclk) disable iff (!hresetn)
        xrise |=> serial_data_out == $past(shreg[15]))
        else $error("serial bit out of order");

endmodule // sarop_port

// File: dv/sarop_host_model.sv
// sarop_host_model: host side serial master for the converter output port
// assumes the bench raises go once per frame; clock idles low between frames
`timescale 1ns/1ps
module sarop_host_model (
    input  wire logic        go,
    input  wire logic [17:0] tag_pattern,
    input  wire logic        serial_data_out,
    output logic             serial_clock_in,
    output logic             tag_in,
    output logic             frame_busy,
    output logic [17:0]      seen_bits
);
    // idle levels; tag starts high so the internal tag level is not a default 0
    initial begin
        serial_clock_in = 1'b0;
        tag_in = 1'b1;
        frame_busy = 1'b0;
        seen_bits = '0;
    end

    // one frame of 18 pulses, 400 ns period, half high
    always @(posedge go) begin
        frame_busy = 1'b1;
        #13;  // phase unrelated to hclk
        for (int i = 0; i < 18; i++) begin
            #100 tag_in = tag_pattern[i];  // changes well away from the rise
            #100 serial_clock_in = 1'b1;
            #200 seen_bits[i] = serial_data_out;  // value valid at rise i+1
            serial_clock_in = 1'b0;
        end
        frame_busy = 1'b0;
    end
endmodule // sarop_host_model

// File: dv/tb.sv
// tb: self-checking bench for sarop_port with a queue model of results
// assumes default CONV_CYCLES and zero-wait ahb-lite answers
`timescale 1ns/1ps
module tb;
    logic                   hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]            haddr, hwdata, hrdata, rd;
    logic [1:0]             htrans;
    logic [2:0]             hsize;
    logic                   cs_n, rc, bsel, css, sclk, tag, sdo, sck_o, sck_oe;
    logic                   busy_n, fbusy, poe, go;
    logic [7:0]             pdo;
    logic [17:0]            tag_pat, seen;
    logic [15:0]            sh;
    sarop_pkg::sarop_pins_t pins;
    integer                 seed = 32'hb1a0a131;
    int                     n_errors = 0;
    int                     check_count = 0;
    int                     pulses;
    int                     exp_q[$];

    assign pins = {cs_n, rc, bsel, css, sclk, tag};

    sarop_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pins(pins), .parallel_data_out(pdo), .parallel_data_oe(poe),
        .serial_data_out(sdo), .serial_bit_clock_out(sck_o),
        .serial_bit_clock_oe(sck_oe), .busy_n(busy_n));
    sarop_host_model host_u (.go(go), .tag_pattern(tag_pat), .serial_data_out(sdo),
        .serial_clock_in(sclk), .tag_in(tag), .frame_busy(fbusy), .seen_bits(seen));

    // 20 mhz clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // internal mode: each high cycle of the bit clock is one pulse
    always @(posedge hclk) begin
        if (sck_o === 1'b1) begin
            sh <= {sh[14:0], sdo};
            pulses <= pulses + 1;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one single ahb-lite transfer; read data taken at the data phase edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= sarop_pkg::HTRANS_NONSEQ;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0, "hresp");
    endtask

    // byte halves, repeat read, then both release combinations
    task automatic par_check(input logic [15:0] e);
        @(posedge hclk);
        cs_n <= 1'b0;
        rc <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            bsel <= i[0];
            repeat (6) @(posedge hclk);
            check(pdo, i[0] ? e[7:0] : e[15:8], "byte");
            check(poe, 1'b1, "bus driven");
        end
        cs_n <= 1'b1;
        repeat (6) @(posedge hclk);
        check(poe, 1'b0, "cs high");
        rc <= 1'b0;
        repeat (6) @(posedge hclk);
        check(poe, 1'b0, "both released");
    endtask

    // one conversion with a random sample; a second start is tried mid-run
    task automatic conv(input logic fmt, input logic ext);
        logic [15:0] s;
        int          n;
        s = $random(seed);
        ahb(1'b1, sarop_pkg::CTRL_ADDR, {31'h0, fmt});
        ahb(1'b1, sarop_pkg::SAMP_ADDR, {16'h0, s});
        exp_q.push_back(fmt ? s : s ^ 16'h8000);
        repeat (2600 / sarop_pkg::CLK_NS) @(posedge hclk);
        @(posedge hclk);
        css <= ext;
        cs_n <= 1'b0;
        rc <= 1'b0;
        bsel <= 1'b0;
        pulses <= 0;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (busy_n !== 1'b0 && n < 20);
        check({31'h0, n <= 6}, 32'h1, "busy drop");
        if (exp_q.size() > 1) check(pdo, exp_q[$-1] >> 8, "previous byte");
        rc <= 1'b1;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            if (n == 10) rc <= 1'b0;  // start while busy, to be ignored
            if (n == 14) rc <= 1'b1;  // released long before busy rises
        end while (busy_n !== 1'b1 && n < 100);
        check(n, sarop_pkg::CONV_CYC, "busy low");
        check(pdo, exp_q[$] >> 8, "byte at busy rise");
        repeat (10) @(posedge hclk);
        check(busy_n, 1'b1, "no retrigger");
        ahb(1'b0, sarop_pkg::STAT_ADDR, 32'h0);
        check(rd, 32'h1, "status idle");
        ahb(1'b0, sarop_pkg::RES_ADDR, 32'h0);
        check(rd, exp_q[$], "result");
        if (!ext) begin
            check(pulses, sarop_pkg::SER_BITS, "pulses");
            check(sh, exp_q[$-1], "internal serial");
            check({sdo, sck_o, sck_oe}, 3'b101, "after frame");
        end
    endtask

    // external clock frame of 18 pulses, result then the first tag bit
    task automatic ext_read(input logic [15:0] e);
        logic [15:0] g;
        int          n;
        @(posedge hclk);
        css <= 1'b1;
        cs_n <= 1'b0;
        rc <= 1'b1;
        tag_pat <= $random(seed);
        repeat (6) @(posedge hclk);
        go <= 1'b1;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (fbusy !== 1'b0 && n < 400);
        go <= 1'b0;
        for (int i = 0; i < 16; i++) g[15 - i] = seen[i + 1];
        check(g, e, "external serial");
        check(seen[17], tag_pat[0], "tag through");
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog well beyond the 30 us the sequence needs
    initial begin
        #200000;
        n_errors++;
        final_report;
    end

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, haddr, htrans, hwdata, go, bsel, tag_pat, sh} = '0;
        hsize = 3'h2;
        {cs_n, rc, css} = 3'b111;
        pulses = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, sarop_pkg::CTRL_ADDR, 32'h0);
        check(rd, sarop_pkg::CTRL_RESET, "ctrl reset");
        ahb(1'b1, 8'h10, 32'hffff_ffff);
        ahb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0, "unmapped");
        conv(1'b1, 1'b1);
        par_check(exp_q[$]);
        conv(1'b0, 1'b1);
        par_check(exp_q[$]);
        conv(1'b1, 1'b0);
        ext_read(exp_q[$]);
        final_report;
    end
endmodule // tb
